// ### core/sbg_core.sv
// Behaviour
// - One 8-bit baud rate timer serves both asynchronous and synchronous operation.
// - The timer runs freely with its period set by baud_divisor.
// - Asynchronous rate is clock/(64(n+1)), or clock/(16(n+1)) with high_speed_select.
// - Synchronous rate is clock/(4(n+1)) and high_speed_select is ignored.
// - Any write to baud_divisor clears the timer at once.
// - As synchronous master the device makes the rate and drives the shift clock.
// - As synchronous slave the device shifts on the clock supplied by the master.
// - The synchronous link has just one bidirectional data line and one clock line.
// - Synchronous operation is half-duplex: transmit or receive, never both.
// - Synchronous mode may be set up as clock master or clock slave.
// - Synchronous characters carry data bits only, no start or stop bits.
// - sync_mode_select set means synchronous operation, clear means asynchronous.
// - clock_source_select set in synchronous mode makes the device the clock master.
// - The master gives exactly one shift clock cycle per data bit and no more.
`timescale 1ns/1ps
`default_nettype none
module sbg_core (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Baud tick for the rest of the serial port.
  output logic             rate_tick,
  // Shift clock line, three signals.
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  // Data line, three signals.
  input  wire logic        sdata_in,
  output logic             sdata_out,
  output logic             sdata_oe
);

  // ***************************************************************
  // Registers and state.
  // ***************************************************************
  sbg_pkg::sbg_req_t   req;
  logic                access;
  logic [7:0]          transmit_status_control;
  logic [7:0]          receive_status_control;
  logic                port_enable;
  logic                tx_enable;
  logic                shift_empty;
  logic [7:0]          baud_divisor;
  logic [7:0]          tx_data;
  logic [7:0]          rx_data;
  logic                tx_pending;
  logic [5:0]          pre_count;
  logic [5:0]          pre_limit;
  logic                pre_done;
  logic [7:0]          baud_count;
  logic                tick;
  logic                divisor_write;
  logic                sync_mode;
  logic                master;
  logic                receiving;
  sbg_pkg::sbg_state_t state;
  logic [3:0]          bit_count;
  logic [7:0]          shifter;
  logic                sck_prev;
  logic                sck_rise;
  logic                sck_fall;
  logic                frame_done;

  assign req.write = pwrite;
  assign req.addr  = paddr;
  assign req.wdata = pwdata;

  // A transfer is taken in its access phase; the slave answers with no wait state.
  assign access        = psel & penable;
  assign divisor_write = access & req.write & (req.addr == sbg_pkg::ADDR_BAUD_RATE_DIVISOR);

  assign sync_mode   = transmit_status_control[sbg_pkg::TX_SYNC_MODE_SELECT];
  assign master      = sync_mode
                     & transmit_status_control[sbg_pkg::TX_CLOCK_SOURCE_SELECT];
  assign tx_enable   = transmit_status_control[sbg_pkg::TX_TRANSMIT_ENABLE];
  assign port_enable = receive_status_control[sbg_pkg::RC_PORT_ENABLE];
  // Either receive enable turns the shared data line round to input.
  assign receiving   = receive_status_control[sbg_pkg::RC_SINGLE_RECEIVE]
                     | receive_status_control[sbg_pkg::RC_CONTINUOUS_RECEIVE];
  // The shift path is empty when nothing is queued and no character is on the line.
  assign shift_empty = ~tx_pending & (state == sbg_pkg::SBG_IDLE);

  // ***************************************************************
  // Baud rate timer.
  // ***************************************************************

  // Prescaler choice; high_speed_select only matters outside synchronous mode.
  always_comb
  begin
    if (sync_mode)
      pre_limit = sbg_pkg::PRE_SYNC;
    else if (transmit_status_control[sbg_pkg::TX_HIGH_SPEED_SELECT])
      pre_limit = sbg_pkg::PRE_ASYNC_HIGH;
    else
      pre_limit = sbg_pkg::PRE_ASYNC_LOW;
  end

  assign pre_done = (pre_count == pre_limit);
  assign tick     = pre_done & (baud_count == baud_divisor);

  // Prescaler; cleared with the timer so a new divisor starts a clean period.
  // A mode change alone does not clear it: a count already past the new limit wraps once,
  // so software should rewrite the divisor after changing mode to get a clean first period.
  always_ff @(posedge clk_sys)
  begin
    if (reset || divisor_write || pre_done)
      pre_count <= 6'd0;
    else
      pre_count <= pre_count + 6'd1;
  end

  // The one shared 8-bit timer, free running and reloading after each tick.
  always_ff @(posedge clk_sys)
  begin
    if (reset || divisor_write)
      baud_count <= 8'd0;
    else if (tick)
      baud_count <= 8'd0;
    else if (pre_done)
      baud_count <= baud_count + 8'd1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rate_tick <= 1'b0;
    else
      rate_tick <= tick;
  end

  // ***************************************************************
  // Register file.
  // ***************************************************************

  // Transmit control; the shift-empty status bit is owned by the link logic, never by writes.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      transmit_status_control <= sbg_pkg::TRANSMIT_STATUS_RESET;
    else if (access && req.write && req.addr == sbg_pkg::ADDR_TRANSMIT_STATUS_CONTROL)
      transmit_status_control <= (req.wdata[7:0] & sbg_pkg::TRANSMIT_STATUS_WMASK)
                               | {6'h00, shift_empty, 1'b0};
    else
      transmit_status_control[sbg_pkg::TX_SHIFT_EMPTY] <= shift_empty;
  end

  // Receive control; single receive ends by itself after one character unless continuous.
  // A write in the same cycle wins, since software is then restarting the receiver.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      receive_status_control <= sbg_pkg::RECEIVE_STATUS_RESET;
    else if (access && req.write && req.addr == sbg_pkg::ADDR_RECEIVE_STATUS_CONTROL)
      receive_status_control <= req.wdata[7:0] & sbg_pkg::RECEIVE_STATUS_WMASK;
    else if (frame_done && !receive_status_control[sbg_pkg::RC_CONTINUOUS_RECEIVE])
      receive_status_control[sbg_pkg::RC_SINGLE_RECEIVE] <= 1'b0;
  end

  // Divisor; the same write also restarts the timer and the prescaler.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      baud_divisor <= sbg_pkg::DIVISOR_RESET;
    else if (divisor_write)
      baud_divisor <= req.wdata[7:0];
  end

  // Read mux and answer; unmapped addresses answer with an error and zero data.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable)
      begin
        case (req.addr)
          sbg_pkg::ADDR_TRANSMIT_STATUS_CONTROL: prdata <= {24'h00_0000, transmit_status_control};
          sbg_pkg::ADDR_RECEIVE_STATUS_CONTROL:  prdata <= {24'h00_0000, receive_status_control};
          sbg_pkg::ADDR_BAUD_RATE_DIVISOR:       prdata <= {24'h00_0000, baud_divisor};
          sbg_pkg::ADDR_TRANSMIT_DATA:           prdata <= {24'h00_0000, tx_data};
          sbg_pkg::ADDR_RECEIVE_DATA:            prdata <= {24'h00_0000, rx_data};
          default:                               pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ***************************************************************
  // Synchronous link.
  // ***************************************************************

  // Slave edges come from the master's clock line, sampled as a plain input.
  assign sck_rise = ~sck_prev & sck_in;
  assign sck_fall = sck_prev & ~sck_in;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      sck_prev <= 1'b0;
    else
      sck_prev <= sck_in;
  end

  // Transmit holding register; a write queues one character.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tx_data    <= 8'h00;
      tx_pending <= 1'b0;
    end
    else if (access && req.write && req.addr == sbg_pkg::ADDR_TRANSMIT_DATA)
    begin
      tx_data    <= req.wdata[7:0];
      tx_pending <= 1'b1;
    end
    else if (state == sbg_pkg::SBG_IDLE && tx_pending && sync_mode
             && port_enable && !receiving && tx_enable && !frame_done)
      tx_pending <= 1'b0;
  end

  // Character framer: eight data bits, no start or stop bits.
  // Master half-periods are baud ticks; slave edges are the master's clock.
  always_ff @(posedge clk_sys)
  begin
    if (reset || !sync_mode || !port_enable)
    begin
      state      <= sbg_pkg::SBG_IDLE;
      bit_count  <= 4'd0;
      shifter    <= 8'h00;
      frame_done <= 1'b0;
      rx_data    <= 8'h00;
    end
    else
    begin
      frame_done <= 1'b0;
      case (state)
        sbg_pkg::SBG_IDLE:
        begin
          bit_count <= 4'd0;
          // One idle cycle after a character lets single receive clear before any restart,
          // otherwise a stale enable would start a second, unwanted run of clocks.
          if (frame_done)
            state <= sbg_pkg::SBG_IDLE;
          else if (receiving)
            state <= sbg_pkg::SBG_LEAD;
          else if (tx_pending && tx_enable)
          begin
            shifter <= tx_data;
            state   <= sbg_pkg::SBG_LEAD;
          end
        end
        sbg_pkg::SBG_LEAD:
          // Leading edge: data holds here; it is sampled and the next bit shifted out at the trailing edge.
          if (master ? tick : sck_rise)
            state <= sbg_pkg::SBG_TRAIL;
        sbg_pkg::SBG_TRAIL:
          if (master ? tick : sck_fall)
          begin
            shifter   <= {sdata_in, shifter[7:1]};
            bit_count <= bit_count + 4'd1;
            if (bit_count == sbg_pkg::CHAR_BITS - 4'd1)
            begin
              state      <= sbg_pkg::SBG_IDLE;
              frame_done <= 1'b1;
              if (receiving)
                rx_data <= {sdata_in, shifter[7:1]};
            end
            else
              state <= sbg_pkg::SBG_LEAD;
          end
        default:
          state <= sbg_pkg::SBG_IDLE;
      endcase
    end
  end

  // Clock pin; driven only as master of an enabled port.
  // The level is gated by the enable as well, so a port switched off mid-bit never
  // leaves a high clock level without a driver behind it.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sck_out <= 1'b0;
      sck_oe  <= 1'b0;
    end
    else
    begin
      sck_oe  <= master & port_enable;
      sck_out <= master & port_enable & (state == sbg_pkg::SBG_TRAIL);
    end
  end

  // Data pin; driven whenever the port is enabled in synchronous mode, released whenever a receive enable is set.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sdata_out <= 1'b0;
      sdata_oe  <= 1'b0;
    end
    else
    begin
      sdata_oe  <= sync_mode & port_enable & ~receiving;
      sdata_out <= shifter[0];
    end
  end

endmodule : sbg_core
`default_nettype wire

// ### core/sbg_pkg.sv
package sbg_pkg;

  // ***************************************************************
  // Register map, one aligned 32-bit word each.
  // ***************************************************************
  localparam logic [11:0] ADDR_TRANSMIT_STATUS_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_RECEIVE_STATUS_CONTROL  = 12'h004;
  localparam logic [11:0] ADDR_BAUD_RATE_DIVISOR       = 12'h008;
  localparam logic [11:0] ADDR_TRANSMIT_DATA           = 12'h00C;
  localparam logic [11:0] ADDR_RECEIVE_DATA            = 12'h010;

  // ***************************************************************
  // Field positions.
  // ***************************************************************
  localparam int TX_CLOCK_SOURCE_SELECT = 7;
  localparam int TX_TRANSMIT_ENABLE     = 5;
  localparam int TX_SYNC_MODE_SELECT    = 4;
  localparam int TX_HIGH_SPEED_SELECT   = 2;
  localparam int TX_SHIFT_EMPTY         = 1;
  localparam int RC_PORT_ENABLE         = 7;
  localparam int RC_SINGLE_RECEIVE      = 5;
  localparam int RC_CONTINUOUS_RECEIVE  = 4;

  // ***************************************************************
  // Reset values and write masks.
  // ***************************************************************
  localparam logic [7:0] TRANSMIT_STATUS_RESET = 8'h02;
  localparam logic [7:0] TRANSMIT_STATUS_WMASK = 8'hF5;
  localparam logic [7:0] RECEIVE_STATUS_RESET  = 8'h00;
  localparam logic [7:0] RECEIVE_STATUS_WMASK  = 8'hF0;
  localparam logic [7:0] DIVISOR_RESET         = 8'h00;

  // ***************************************************************
  // Prescale counts per baud timer step, less one (rate = clk / ((pre+1)*(n+1))).
  // ***************************************************************
  localparam logic [5:0] PRE_ASYNC_LOW  = 6'd63;
  localparam logic [5:0] PRE_ASYNC_HIGH = 6'd15;
  localparam logic [5:0] PRE_SYNC       = 6'd3;
  localparam logic [3:0] CHAR_BITS      = 4'd8;

  // Bus request bundle.
  typedef struct packed {
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } sbg_req_t;

  typedef enum logic [1:0] {
    SBG_IDLE,
    SBG_LEAD,
    SBG_TRAIL
  } sbg_state_t;

endpackage : sbg_pkg

// ### dv/sbg_core_props.sv
`timescale 1ns/1ps
`default_nettype none
// Watches bus answers, rate tick spacing and the shift clock pins.
module sbg_core_props (
  // Clock, reset and bus.
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Tick and link pins.
  input wire logic        rate_tick,
  input wire logic        sck_in,
  input wire logic        sck_out,
  input wire logic        sck_oe,
  input wire logic        sdata_in,
  input wire logic        sdata_out,
  input wire logic        sdata_oe
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic mapped;
  // Only aligned words up to the receive data register are decoded.
  assign mapped = (paddr <= sbg_pkg::ADDR_RECEIVE_DATA) && (paddr[1:0] == 2'b00);
  // Steps of one bus transfer.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_div_write;
    psel && penable && pready && pwrite && (paddr == sbg_pkg::ADDR_BAUD_RATE_DIVISOR);
  endsequence
  chk_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no answer one cycle after setup");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("answer outside an access cycle");
  chk_error_on_map: assert property (pready |-> (pslverr == !mapped))
    else $error("error flag does not match address decode");
  chk_error_reads_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  chk_tick_min_gap: assert property (rate_tick |=> !rate_tick [*3])
    else $error("rate ticks closer than four cycles");
  chk_divisor_restart: assert property (s_div_write |=> ##1 !rate_tick [*2])
    else $error("tick too soon after divisor write");
  chk_clock_master_only: assert property (sck_out |-> sck_oe)
    else $error("shift clock high without master drive");
  chk_clock_half_len: assert property ($rose(sck_out) |-> sck_out [*4])
    else $error("shift clock high half shorter than a tick period");
endmodule : sbg_core_props
bind sbg_core sbg_core_props u_props (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .rate_tick, .sck_in, .sck_out, .sck_oe, .sdata_in,
  .sdata_out, .sdata_oe);
`default_nettype wire

// ### dv/sbg_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Synchronous peer that follows the clock it is given and never makes one.
module sbg_peer (
  // Link lines.
  input wire logic       sck_line,
  input wire logic       sdata_line,
  // Bench control and results.
  input wire logic [7:0] send_byte,
  input wire logic       restart,
  output logic           sdata_drive,
  output logic [7:0]     got_byte,
  output int             edges
);
  int idx;
  // Sample on the leading clock edge, least significant bit first.
  always @(posedge sck_line or posedge restart)
    if (restart)
    begin
      edges <= 0;
      got_byte <= 8'h00;
    end
    else
    begin
      edges <= edges + 1;
      got_byte <= {sdata_line, got_byte[7:1]};
    end
  // Move to the next data bit on the trailing edge; no framing bits exist.
  always @(negedge sck_line or posedge restart)
    if (restart)
      idx <= 0;
    else
      idx <= idx + 1;
  assign sdata_drive = send_byte[idx[2:0]];
endmodule : sbg_peer
`default_nettype wire

// ### dv/serial_baud_rate_generator_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module serial_baud_rate_generator_test;
  logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr, rate_tick;
  logic        sck_in, sck_out, sck_oe, sdata_in, sdata_out, sdata_oe, restart, peer_bit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [7:0]  send_byte, got_byte;
  logic        ev, slv_clk;
  int          edges, fail_count, compares, n;
  logic [31:0] md[4] = '{32'h0000_0000, 32'h0000_0004, 32'h0000_0010, 32'h0000_0014};
  int          nv[4] = '{2, 2, 4, 4};
  int          pv[4] = '{192, 48, 20, 20};
  // When the design does not drive the clock line the bench does; it idles low.
  assign sck_in = sck_oe ? sck_out : slv_clk;
  assign sdata_in = sdata_oe ? sdata_out : peer_bit;
  sbg_core dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rate_tick, .sck_in, .sck_out, .sck_oe, .sdata_in, .sdata_out, .sdata_oe);
  sbg_peer peer (.sck_line(sck_in), .sdata_line(sdata_in), .send_byte, .restart,
    .sdata_drive(peer_bit), .got_byte, .edges);
  // Free-running 250 MHz clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // One bus transfer; request held until pready is seen at a rising edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (int i = 0; i <= 20; i++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
      if (i == 20)
      begin
        fail_count++;
        report_and_stop();
      end
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, ev);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000, rv, ev);
    `CHK(rv, x)
  endtask : rd
  // Cycles until the next rate tick, bounded.
  task tick(output int c);
    for (c = 1; c <= 300; c++)
    begin
      @(posedge clk_sys);
      if (rate_tick === 1'b1) return;
    end
    fail_count++;
    report_and_stop();
  endtask : tick
  task pulse_restart;
    restart <= 1'b1;
    @(posedge clk_sys);
    restart <= 1'b0;
  endtask : pulse_restart
  // Main sequence.
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, slv_clk, fail_count, compares} = '0;
    reset = 1'b1;
    restart = 1'b1;
    send_byte = 8'h3C;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    restart <= 1'b0;
    rd(sbg_pkg::ADDR_TRANSMIT_STATUS_CONTROL, 32'h0000_0002);
    rd(sbg_pkg::ADDR_RECEIVE_STATUS_CONTROL, 32'h0000_0000);
    rd(sbg_pkg::ADDR_BAUD_RATE_DIVISOR, 32'h0000_0000);
    apb(1'b0, 12'h014, 32'h0000_0000, rv, ev);
    `CHK({ev, rv}, {1'b1, 32'h0000_0000})
    wr(sbg_pkg::ADDR_TRANSMIT_STATUS_CONTROL, 32'h0000_00FF);
    rd(sbg_pkg::ADDR_TRANSMIT_STATUS_CONTROL, 32'h0000_00F7);
    // Tick period for every multiplier, high speed ignored in synchronous mode.
    for (int k = 0; k < 4; k++)
    begin
      wr(sbg_pkg::ADDR_TRANSMIT_STATUS_CONTROL, md[k]);
      wr(sbg_pkg::ADDR_BAUD_RATE_DIVISOR, nv[k]);
      tick(n);
      tick(n);
      `CHK(n, pv[k])
    end
    // A new divisor must not wait out the old long period.
    wr(sbg_pkg::ADDR_TRANSMIT_STATUS_CONTROL, 32'h0000_0000);
    wr(sbg_pkg::ADDR_BAUD_RATE_DIVISOR, 32'h0000_00C8);
    repeat (50) @(posedge clk_sys);
    wr(sbg_pkg::ADDR_BAUD_RATE_DIVISOR, 32'h0000_0001);
    tick(n);
    `CHK(n inside {[124:132]}, 1'b1)
    // Master transmit of one character.
    wr(sbg_pkg::ADDR_BAUD_RATE_DIVISOR, 32'h0000_0000);
    wr(sbg_pkg::ADDR_RECEIVE_STATUS_CONTROL, 32'h0000_0080);
    wr(sbg_pkg::ADDR_TRANSMIT_STATUS_CONTROL, 32'h0000_00B0);
    pulse_restart();
    wr(sbg_pkg::ADDR_TRANSMIT_DATA, 32'h0000_00A5);
    repeat (150) @(posedge clk_sys);
    `CHK(got_byte, 8'hA5)
    `CHK(edges, 8)
    rd(sbg_pkg::ADDR_TRANSMIT_STATUS_CONTROL, 32'h0000_00B2);
    // Master single receive; the data line is released meanwhile.
    pulse_restart();
    wr(sbg_pkg::ADDR_RECEIVE_STATUS_CONTROL, 32'h0000_00A0);
    repeat (2) @(posedge clk_sys);
    `CHK(sdata_oe, 1'b0)
    repeat (150) @(posedge clk_sys);
    `CHK(edges, 8)
    rd(sbg_pkg::ADDR_RECEIVE_DATA, 32'h0000_003C);
    rd(sbg_pkg::ADDR_RECEIVE_STATUS_CONTROL, 32'h0000_0080);
    // Slave setting leaves the clock line undriven; pins settle one cycle after the write.
    wr(sbg_pkg::ADDR_TRANSMIT_STATUS_CONTROL, 32'h0000_0030);
    repeat (2) @(posedge clk_sys);
    `CHK({sck_oe, sdata_oe}, 2'b01)
    // Slave transmit of one character on a clock that the bench makes.
    pulse_restart();
    wr(sbg_pkg::ADDR_TRANSMIT_DATA, 32'h0000_005A);
    repeat (8)
    begin
      repeat (4) @(posedge clk_sys);
      slv_clk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      slv_clk <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    `CHK(got_byte, 8'h5A)
    `CHK(edges, 8)
    rd(sbg_pkg::ADDR_TRANSMIT_STATUS_CONTROL, 32'h0000_0032);
    wr(sbg_pkg::ADDR_TRANSMIT_STATUS_CONTROL, 32'h0000_0020);
    repeat (2) @(posedge clk_sys);
    `CHK({sck_oe, sdata_oe}, 2'b00)
    report_and_stop();
  end
endmodule : serial_baud_rate_generator_test
`default_nettype wire
